// >>> design/bom_ctrl.v
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "bom_defines.vh"
module bom_ctrl #(
   parameter FAST_CYC = `BOM_FAST_CYC,
   parameter SLOW_CYC = `BOM_SLOW_CYC
) (
   input wire clk,
   input wire sys_rst,
   input wire [`BOM_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire write_protect_unlock,
   input wire [7:0] detector_config_fuse,
   input wire sleep_deep,
   input wire debug_halt,
   input wire det_below_async,
   input wire ew_below_async,
   output reg [1:0] det_mode,
   output reg det_enable,
   output reg det_strobe,
   output reg [2:0] trip_level_code,
   output reg [1:0] early_warning_level,
   output reg early_warning_enable,
   output wire continuous_hold_at_wake,
   output wire early_warning_irq
);
   // ----------------------------------------------------------------
   // Control registers.
   // ----------------------------------------------------------------
   reg rate_q;
   reg [1:0] act_q;
   reg [1:0] slp_q;
   reg [2:0] lvl_q;
   reg [1:0] ewlvl_q;
   reg [1:0] trig_q;
   reg ie_q;
   reg flag_q;
   reg state_q;
   reg prev_q;
   reg prev_ok_q;
   reg [1:0] cur_mode;
   wire [1:0] sync_w;
   wire tick_w;
   wire ev_w;
   wire eval_w;
   wire rise_w;
   wire fall_w;
   wire wr_mode_w;
   wire wr_flag_w;
   wire wr_ewlvl_w;
   wire wr_ictl_w;
   wire trig_hit_w;
   reg rate_d;
   reg [1:0] slp_d;
   reg [1:0] ewlvl_d;
   reg [1:0] trig_d;
   reg ie_d;
   reg flag_d;
   reg state_d;
   reg prev_d;
   reg prev_ok_d;

   function hit;
      input [`BOM_ADDR_W-1:0] a;
      input [`BOM_ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   assign wr_mode_w = reg_wr && hit(reg_addr, `BOM_OFF_MODE_CTRL);
   assign wr_flag_w = reg_wr && hit(reg_addr, `BOM_OFF_EW_FLAGS);
   assign wr_ewlvl_w = reg_wr && hit(reg_addr, `BOM_OFF_EW_LEVEL);
   assign wr_ictl_w = reg_wr && hit(reg_addr, `BOM_OFF_EW_EARLY_WARNING_INTERRUPT_CONTROL);

   // ----------------------------------------------------------------
   // Register writes, next values.
   // ----------------------------------------------------------------
   always @* begin
      rate_d = rate_q;
      slp_d = slp_q;
      ewlvl_d = ewlvl_q;
      trig_d = trig_q;
      ie_d = ie_q;
      if (wr_mode_w) begin
         rate_d = reg_wdata[`BOM_RATE_BIT];
         if (write_protect_unlock) begin
            slp_d = reg_wdata[`BOM_SLP_HI:`BOM_SLP_LO];
         end
      end
      if (wr_ewlvl_w) begin
         ewlvl_d = reg_wdata[`BOM_EWL_HI:`BOM_EWL_LO];
      end
      if (wr_ictl_w) begin
         trig_d = reg_wdata[`BOM_CFG_HI:`BOM_CFG_LO];
         ie_d = reg_wdata[`BOM_IE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Register state; mode, rate and trip fields loaded from the fuse byte during reset, the rest cleared.
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         rate_q <= detector_config_fuse[`BOM_RATE_BIT];
         act_q <= detector_config_fuse[`BOM_ACT_HI:`BOM_ACT_LO];
         slp_q <= detector_config_fuse[`BOM_SLP_HI:`BOM_SLP_LO];
         lvl_q <= detector_config_fuse[`BOM_TRIP_HI:`BOM_TRIP_LO];
         ewlvl_q <= 2'h0;
         trig_q <= 2'h0;
         ie_q <= 1'b0;
      end else begin
         rate_q <= rate_d;
         slp_q <= slp_d;
         ewlvl_q <= ewlvl_d;
         trig_q <= trig_d;
         ie_q <= ie_d;
      end
   end

   // ----------------------------------------------------------------
   // Current detector mode.
   // ----------------------------------------------------------------
   always @* begin
      if (sleep_deep) begin
         cur_mode = slp_q;
      end else if (act_q == `BOM_MODE_HOLD) begin
         cur_mode = `BOM_MODE_CONT;
      end else begin
         cur_mode = act_q;
      end
   end
   assign continuous_hold_at_wake = (act_q == `BOM_MODE_HOLD);

   bom_sampler #(
      .FAST_CYC(FAST_CYC),
      .SLOW_CYC(SLOW_CYC)
   ) u_sampler (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(cur_mode == `BOM_MODE_SAMP),
      .slow_sel(rate_q),
      .tick(tick_w)
   );

   bom_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({det_below_async, ew_below_async}),
      .sync_out(sync_w)
   );

   assign ev_w = (cur_mode == `BOM_MODE_CONT) ||
                 (cur_mode == `BOM_MODE_SAMP && tick_w);
   assign eval_w = ev_w && ie_q;
   assign fall_w = prev_ok_q && !prev_q && sync_w[0];
   assign rise_w = prev_ok_q && prev_q && !sync_w[0];
   assign trig_hit_w = (trig_q == `BOM_TRIG_BELOW && fall_w) ||
                       (trig_q == `BOM_TRIG_ABOVE && rise_w) ||
                       (trig_q == `BOM_TRIG_CROSS && (fall_w || rise_w));

   // ----------------------------------------------------------------
   // Monitor state and flag, next values.
   // ----------------------------------------------------------------
   always @* begin
      flag_d = flag_q;
      state_d = state_q;
      prev_d = prev_q;
      prev_ok_d = prev_ok_q;
      if (eval_w) begin
         state_d = sync_w[0];
         prev_d = sync_w[0];
         prev_ok_d = 1'b1;
      end else if (!ie_q || cur_mode == `BOM_MODE_DIS) begin
         prev_ok_d = 1'b0;
      end
      if (wr_flag_w && reg_wdata[`BOM_FLAG_BIT]) begin
         flag_d = 1'b0;
      end
      if (eval_w && trig_hit_w) begin
         flag_d = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Monitor state and flag.
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
         state_q <= 1'b0;
         prev_q <= 1'b0;
         prev_ok_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         state_q <= state_d;
         prev_q <= prev_d;
         prev_ok_q <= prev_ok_d;
      end
   end

   assign early_warning_irq = ie_q && flag_q && !debug_halt;

   // ----------------------------------------------------------------
   // Analog-facing outputs.
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         det_mode <= `BOM_MODE_DIS;
         det_enable <= 1'b0;
         det_strobe <= 1'b0;
         trip_level_code <= 3'h0;
         early_warning_level <= 2'h0;
         early_warning_enable <= 1'b0;
      end else begin
         det_mode <= cur_mode;
         det_enable <= (cur_mode != `BOM_MODE_DIS);
         det_strobe <= ev_w;
         trip_level_code <= lvl_q;
         early_warning_level <= ewlvl_q;
         early_warning_enable <= ie_q && (cur_mode != `BOM_MODE_DIS);
      end
   end

   // ----------------------------------------------------------------
   // Register reads, data one cycle after the strobe.
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (hit(reg_addr, `BOM_OFF_MODE_CTRL)) begin
         reg_rdata <= {3'h0, rate_q, act_q, slp_q};
      end else if (hit(reg_addr, `BOM_OFF_LEVEL_CTRL)) begin
         reg_rdata <= {5'h00, lvl_q};
      end else if (hit(reg_addr, `BOM_OFF_EW_LEVEL)) begin
         reg_rdata <= {6'h00, ewlvl_q};
      end else if (hit(reg_addr, `BOM_OFF_EW_EARLY_WARNING_INTERRUPT_CONTROL)) begin
         reg_rdata <= {5'h00, trig_q, ie_q};
      end else if (hit(reg_addr, `BOM_OFF_EW_FLAGS)) begin
         reg_rdata <= {7'h00, flag_q};
      end else if (hit(reg_addr, `BOM_OFF_EW_STATE)) begin
         reg_rdata <= {7'h00, state_q};
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// >>> inc/bom_defines.vh
`ifndef BOM_DEFINES_VH
`define BOM_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BOM_ADDR_W 4
`define BOM_OFF_MODE_CTRL 4'h0
`define BOM_OFF_LEVEL_CTRL 4'h1
`define BOM_OFF_EW_LEVEL 4'h8
`define BOM_OFF_EW_EARLY_WARNING_INTERRUPT_CONTROL 4'h9
`define BOM_OFF_EW_FLAGS 4'hA
`define BOM_OFF_EW_STATE 4'hB

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BOM_RATE_BIT 4
`define BOM_ACT_HI 3
`define BOM_ACT_LO 2
`define BOM_SLP_HI 1
`define BOM_SLP_LO 0
`define BOM_CFG_HI 2
`define BOM_CFG_LO 1
`define BOM_IE_BIT 0
`define BOM_FLAG_BIT 0
`define BOM_TRIP_HI 7
`define BOM_TRIP_LO 5
`define BOM_EWL_HI 1
`define BOM_EWL_LO 0

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define BOM_MODE_DIS 2'h0
`define BOM_MODE_CONT 2'h1
`define BOM_MODE_SAMP 2'h2
`define BOM_MODE_HOLD 2'h3
`define BOM_TRIG_BELOW 2'h0
`define BOM_TRIG_ABOVE 2'h1
`define BOM_TRIG_CROSS 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BOM_CLK_HZ 100000000
`define BOM_FAST_HZ 1000
`define BOM_SLOW_HZ 125
`define BOM_FAST_CYC (`BOM_CLK_HZ / `BOM_FAST_HZ)
`define BOM_SLOW_CYC (`BOM_CLK_HZ / `BOM_SLOW_HZ)

`endif

// >>> design/bom_sync.v
`timescale 1ns/100ps
`include "bom_defines.vh"
module bom_sync #(
   parameter WIDTH = 2
) (
   input wire clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   // ----------------------------------------------------------------
   // Two-stage synchroniser per bit.
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge clk) begin
            if (sys_rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               sync_q <= meta_q;
            end
         end
         assign sync_out[i] = sync_q;
      end
   endgenerate
endmodule

// >>> design/bom_sampler.v
`timescale 1ns/100ps
`include "bom_defines.vh"
module bom_sampler #(
   parameter FAST_CYC = `BOM_FAST_CYC,
   parameter SLOW_CYC = `BOM_SLOW_CYC
) (
   input wire clk,
   input wire sys_rst,
   input wire run,
   input wire slow_sel,
   output reg tick
);
   // ----------------------------------------------------------------
   // Sample enable divider, one-cycle pulse per period.
   // ----------------------------------------------------------------
   reg [23:0] cnt_q;
   wire [23:0] last_w;
   wire [31:0] fast_last_w;
   wire [31:0] slow_last_w;
   assign fast_last_w = FAST_CYC - 1;
   assign slow_last_w = SLOW_CYC - 1;
   assign last_w = slow_sel ? slow_last_w[23:0] : fast_last_w[23:0];
   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 24'h000000;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= 24'h000000;
         tick <= 1'b0;
      end else if (cnt_q >= last_w) begin
         cnt_q <= 24'h000000;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 24'h000001;
         tick <= 1'b0;
      end
   end
endmodule

// >>> sim/bom_supply_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Supply comparators
// ----------------------------------------------------------------
module bom_supply_model (
   input logic supply_low,
   output logic det_below_async,
   output logic ew_below_async
);
   // ew_below_async moves off the clock grid, as analog comparators do; det_below_async is tied low.
   assign #3 ew_below_async = supply_low;
   assign det_below_async = 1'b0;
endmodule

// >>> sim/bom_ctrl_sva.sv
`timescale 1ns/100ps
`include "bom_defines.vh"
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module bom_chk (
   input logic clk,
   input logic sys_rst,
   input logic [`BOM_ADDR_W-1:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic debug_halt,
   input logic [1:0] det_mode,
   input logic det_enable,
   input logic [2:0] trip_level_code,
   input logic [1:0] early_warning_level,
   input logic early_warning_enable,
   input logic early_warning_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_halt_mask: assert property (debug_halt |-> !early_warning_irq)
      else $error("irq seen during halt");
   chk_en_mode: assert property (det_enable == (det_mode != 2'h0))
      else $error("enable does not follow mode");
   chk_ew_off: assert property (!det_enable |-> !early_warning_enable)
      else $error("monitor on with detector off");
   chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_rd_unmap: assert property ($past(reg_rd) && ($past(reg_addr)
      inside {[4'h2:4'h7], [4'hC:4'hF]}) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_lvl_read: assert property ($past(reg_rd)
      && $past(reg_addr) == 4'h1 |-> reg_rdata == {5'h00, trip_level_code})
      else $error("level read wrong");
   chk_trip_fix: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
      |-> $stable(trip_level_code))
      else $error("trip level moved");
   chk_irq_hold: assert property ($past(early_warning_irq)
      && !$past(reg_wr) && !debug_halt |-> early_warning_irq)
      else $error("irq dropped");
   chk_lvl_write: assert property ($past(reg_wr, 2)
      && $past(reg_addr, 2) == 4'h8
      |-> early_warning_level == $past(reg_wdata[1:0], 2))
      else $error("monitor level not written");
endmodule
bind bom_ctrl bom_chk chk_u (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(debug_halt),
   .det_mode(det_mode), .det_enable(det_enable),
   .trip_level_code(trip_level_code),
   .early_warning_level(early_warning_level),
   .early_warning_enable(early_warning_enable),
   .early_warning_irq(early_warning_irq));

// >>> sim/tb.sv
`timescale 1ns/100ps
`include "bom_defines.vh"
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb;
   logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, unlock = 0;
   logic sleep_deep = 0, debug_halt = 0, supply_low = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, fuse = 8'h00, reg_rdata, d;
   logic [1:0] det_mode, ew_lvl;
   logic [2:0] trip;
   logic det_en, det_strobe, ew_en, hold, irq, det_b, ew_b;
   int err_count = 0, n_tests = 0, c, n, v;
   always #5 clk = ~clk;
   bom_supply_model sup_u (.supply_low(supply_low),
      .det_below_async(det_b), .ew_below_async(ew_b));
   bom_ctrl #(.FAST_CYC(10), .SLOW_CYC(80)) dut_u (.clk(clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .write_protect_unlock(unlock), .detector_config_fuse(fuse),
      .sleep_deep(sleep_deep), .debug_halt(debug_halt),
      .det_below_async(det_b), .ew_below_async(ew_b),
      .det_mode(det_mode), .det_enable(det_en), .det_strobe(det_strobe),
      .trip_level_code(trip), .early_warning_level(ew_lvl),
      .early_warning_enable(ew_en), .continuous_hold_at_wake(hold),
      .early_warning_irq(irq));
   function logic exp_flag(input int cf, input logic fall);
      exp_flag = fall ? (cf == 0 || cf == 2) : (cf == 1 || cf == 2);
   endfunction
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] w);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= w; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask
   task rst(input logic [7:0] f);
      @(posedge clk);
      fuse <= f; sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   task settle(input int k);
      repeat (k) @(posedge clk);
   endtask
   task wait_mode(input logic [1:0] m);
      for (int i = 0; i < 50 && det_mode !== m; i++) @(posedge clk);
      chk({6'h00, det_mode}, {6'h00, m});
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      conclude;
   end
   initial begin
      v = $urandom(32'h0363);
      rst(8'hE6);
      rd(4'h0); chk(d, 8'h06);
      rd(4'h1); chk(d, 8'h07);
      for (c = 8; c < 12; c++) begin
         rd(c[3:0]); chk(d, 8'h00);
      end
      wr(4'h5, 8'hFF); rd(4'h5); chk(d, 8'h00);
      wr(4'h0, 8'h1F); rd(4'h0); chk(d, 8'h16);
      wr(4'h1, 8'hFF); rd(4'h1); chk(d, 8'h07);
      unlock <= 1'b1; wr(4'h0, 8'h10); unlock <= 1'b0;
      rd(4'h0); chk(d, 8'h14);
      $display("test registers done");
      wr(4'h9, 8'h01); sleep_deep <= 1'b1; wait_mode(2'h0);
      chk({7'h00, ew_en}, 8'h00);
      supply_low <= 1'b1; settle(6);
      rd(4'hA); chk(d, 8'h00);
      sleep_deep <= 1'b0; wait_mode(2'h1);
      supply_low <= 1'b0; settle(6); wr(4'hA, 8'h01);
      $display("test sleep done");
      for (c = 0; c < 4; c++) begin
         wr(4'h9, {5'h00, c[1:0], 1'b1}); wr(4'hA, 8'h01);
         chk({7'h00, ew_en}, 8'h01);
         supply_low <= 1'b1; settle(6);
         rd(4'hA); chk(d, {7'h00, exp_flag(c, 1)});
         chk({7'h00, irq}, {7'h00, exp_flag(c, 1)});
         rd(4'hB); chk(d, 8'h01);
         debug_halt <= 1'b1; settle(1);
         chk({7'h00, irq}, 8'h00);
         debug_halt <= 1'b0;
         wr(4'hA, 8'h00); rd(4'hA); chk(d, {7'h00, exp_flag(c, 1)});
         wr(4'hA, 8'h01); supply_low <= 1'b0; settle(6);
         rd(4'hA); chk(d, {7'h00, exp_flag(c, 0)});
      end
      wr(4'h9, 8'h00); wr(4'hA, 8'h01); supply_low <= 1'b1; settle(6);
      rd(4'hA); chk(d, 8'h00);
      supply_low <= 1'b0; settle(6);
      repeat (4) begin
         v = $urandom % 3; wr(4'h8, v[7:0]);
         rd(4'h8); chk(d, {6'h00, v[1:0]});
      end
      $display("test monitor done");
      rst(8'h48);
      rd(4'h0); chk(d, 8'h08);
      wait_mode(2'h2);
      n = 0;
      for (c = 0; c < 40; c++) begin
         @(posedge clk) #1;
         if (det_strobe === 1'b1) n++;
      end
      chk(n[7:0], 8'h04);
      wr(4'h9, 8'h01); settle(15); supply_low <= 1'b1; settle(15);
      rd(4'hA); chk(d, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(4'h0, 8'h10); rd(4'h0); chk(d, 8'h18);
      settle(80); n = 0;
      for (c = 0; c < 160; c++) begin
         @(posedge clk);
         if (det_strobe === 1'b1) n++;
      end
      chk(n[7:0], 8'h02);
      $display("test sampled done");
      rst(8'h2E); wait_mode(2'h1);
      chk({7'h00, hold}, 8'h01);
      sleep_deep <= 1'b1; wait_mode(2'h2);
      sleep_deep <= 1'b0; wait_mode(2'h1);
      $display("test modes done");
      conclude;
   end
endmodule
